// >>> src/radio_rx_pkg.sv
// constants and types shared by the receive-enable and interrupt-mask register bank
package radio_rx_pkg;
   // register indices; the byte address on the bus is four times the index
   localparam logic [15:0] IDX_FRAME_OPTS  = 16'h618A;
   localparam logic [15:0] IDX_RX_MASK     = 16'h618B;
   localparam logic [15:0] IDX_MASK_SET    = 16'h618C;
   localparam logic [15:0] IDX_MASK_CLR    = 16'h618D;
   localparam logic [15:0] IDX_IRQ_MASK_LO = 16'h61A3;
   localparam logic [15:0] IDX_IRQ_MASK_HI = 16'h61A4;
   localparam logic [15:0] IDX_IRQ_STAT_LO = 16'h61B0;
   localparam logic [15:0] IDX_IRQ_STAT_HI = 16'h61B1;
   localparam logic [15:0] IDX_RX_CTRL     = 16'h61B2;
   // bus geometry
   localparam int          ADR_W           = 18;
   // frame handling option bits
   localparam int          BIT_PEND_OVR    = 2;
   localparam int          BIT_SKIP_UNDER  = 1;
   localparam int          BIT_ARM_RX_TX   = 0;
   localparam logic [2:0]  FRAME_OPTS_RST  = 3'h1;
   // receive-enable mask bits touched by strobes
   localparam int          BIT_RX_ON       = 7;
   localparam int          BIT_TX_ON       = 6;
   localparam int          BIT_MASK5       = 5;
   localparam logic [7:0]  RX_MASK_RST     = 8'h00;
   // interrupt sources: bits 6:0 low byte, bit 7 mask emptied, 13:8 high byte 5:0
   localparam int          IRQ_W           = 15;
   localparam int          BIT_MASK_EMPTY  = 7;
   localparam logic [14:0] IRQ_IMPL        = 15'h3FFF;
   localparam logic [14:0] IRQ_RST         = 15'h0000;
   // receive modes
   localparam logic [1:0]  RX_MODE_NORMAL  = 2'h0;
   localparam logic [1:0]  RX_MODE_LOOP    = 2'h2;
   localparam logic [1:0]  RX_MODE_NOSYNC  = 2'h3;

   typedef struct packed {
      logic rx_on;
      logic tx_on;
      logic rf_off;
      logic bit5_set;
      logic bit5_clr;
   } strobes_s;

   typedef struct packed {
      logic [6:0] lo;
      logic [5:0] hi;
   } irq_src_s;

   typedef struct packed {
      logic idle;
      logic tx_done;
      logic ack_done;
   } fsm_state_s;
endpackage : radio_rx_pkg

// >>> src/radio_rx_enable_and_irq_masks.sv
// receive-enable mask, frame handling options and radio interrupt masks behind a wishbone slave
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module radio_rx_enable_and_irq_masks (
   // clock and reset
   input  wire logic                           clk_in,
   input  wire logic                           rst_in,
   // wishbone slave
   input  wire logic                           wb_cyc_in,
   input  wire logic                           wb_stb_in,
   input  wire logic                           wb_we_in,
   input  wire logic [radio_rx_pkg::ADR_W-1:0] wb_adr_in,
   input  wire logic [3:0]                     wb_sel_in,
   input  wire logic [31:0]                    wb_dat_in,
   output logic      [31:0]                    wb_dat_out,
   output logic                                wb_ack_out,
   // strobes from the command strobe processor
   input  wire radio_rx_pkg::strobes_s         strobes_in,
   // main state machine and transmitter status
   input  wire radio_rx_pkg::fsm_state_s       fsm_in,
   input  wire logic                           fsm_pending_in,
   input  wire logic                           tx_underflow_in,
   // raw interrupt sources
   input  wire radio_rx_pkg::irq_src_s         irq_src_in,
   // controls towards the radio
   output logic                                ack_pending_out,
   output logic                                tx_abort_out,
   output logic                                receiver_on_out,
   output logic                                rx_to_fifo_out,
   output logic                                rx_ignore_overflow_out,
   output logic                                symbol_search_off_out,
   output logic      [7:0]                     receive_enable_mask_out,
   // interrupt
   output logic                                irq_out
);

   logic [2:0]                     opts_q;
   logic [2:0]                     opts_d;
   logic [7:0]                     rx_mask_q;
   logic [7:0]                     rx_mask_d;
   logic [14:0]                    irq_mask_q;
   logic [14:0]                    irq_mask_d;
   logic [14:0]                    irq_stat_q;
   logic [14:0]                    irq_stat_d;
   logic [1:0]                     rx_mode_q;
   logic [1:0]                     rx_mode_d;
   logic                           ack_q;
   logic                           ack_d;
   logic [31:0]                    rdat_q;
   logic [31:0]                    rdat_d;
   logic                           pend_q;
   logic                           pend_d;
   logic                           abort_q;
   logic                           abort_d;
   logic                           rx_on_q;
   logic                           rx_on_d;
   logic [2:0]                     mode_out_q;
   logic [2:0]                     mode_out_d;
   logic                           irq_q;
   logic                           irq_d;

   logic                           wr;
   logic [15:0]                    idx;
   logic [7:0]                     wbyte;
   logic [7:0]                     csp_mask;
   logic [7:0]                     cpu_touch;
   logic [7:0]                     cpu_val;
   logic [14:0]                    events;
   logic [14:0]                    clr_bits;

   assign idx   = wb_adr_in[radio_rx_pkg::ADR_W-1:2];
   assign wbyte = wb_dat_in[7:0];
   // a request is served once; the ack cycle itself does not repeat the write
   assign wr    = wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0] && !ack_q;

   // bus handshake and read data
   always_comb begin
      ack_d  = wb_cyc_in && wb_stb_in && !ack_q;
      rdat_d = 32'h0000_0000;
      unique case (idx)
         radio_rx_pkg::IDX_FRAME_OPTS:  rdat_d[2:0] = opts_q;
         radio_rx_pkg::IDX_RX_MASK:     rdat_d[7:0] = rx_mask_q;
         radio_rx_pkg::IDX_IRQ_MASK_LO: rdat_d[7:0] = irq_mask_q[7:0];
         radio_rx_pkg::IDX_IRQ_MASK_HI: rdat_d[6:0] = irq_mask_q[14:8];
         radio_rx_pkg::IDX_IRQ_STAT_LO: rdat_d[7:0] = irq_stat_q[7:0];
         radio_rx_pkg::IDX_IRQ_STAT_HI: rdat_d[6:0] = irq_stat_q[14:8];
         radio_rx_pkg::IDX_RX_CTRL:     rdat_d[1:0] = rx_mode_q;
         default:                       rdat_d      = 32'h0000_0000;
      endcase
      if (!ack_d) begin
         rdat_d = 32'h0000_0000;
      end
   end

   // option bits and receive mode
   always_comb begin
      opts_d    = opts_q;
      rx_mode_d = rx_mode_q;
      if (wr && idx == radio_rx_pkg::IDX_FRAME_OPTS) begin
         opts_d = wbyte[2:0];
      end
      if (wr && idx == radio_rx_pkg::IDX_RX_CTRL) begin
         rx_mode_d = wbyte[1:0];
      end
   end

   // receive-enable mask: strobe path first, bus ports override on the bits they touch
   always_comb begin
      csp_mask = rx_mask_q;
      if (strobes_in.rx_on) begin
         csp_mask[radio_rx_pkg::BIT_RX_ON] = 1'b1;
      end
      if (strobes_in.tx_on && opts_q[radio_rx_pkg::BIT_ARM_RX_TX]) begin
         csp_mask[radio_rx_pkg::BIT_TX_ON] = 1'b1;
      end
      if (strobes_in.bit5_set) begin
         csp_mask[radio_rx_pkg::BIT_MASK5] = 1'b1;
      end
      if (strobes_in.bit5_clr) begin
         csp_mask[radio_rx_pkg::BIT_MASK5] = 1'b0;
      end
      if (strobes_in.rf_off) begin
         csp_mask = 8'h00;
      end
      cpu_touch = 8'h00;
      cpu_val   = 8'h00;
      if (wr && idx == radio_rx_pkg::IDX_MASK_SET) begin
         cpu_touch = wbyte;
         cpu_val   = 8'hFF;
      end
      if (wr && idx == radio_rx_pkg::IDX_MASK_CLR) begin
         cpu_touch = wbyte;
         cpu_val   = 8'h00;
      end
      // untouched bits keep the strobe result, touched bits take the bus value
      rx_mask_d = (cpu_touch & cpu_val) | (~cpu_touch & csp_mask);
   end

   // interrupt masks, sticky status with write-one-to-clear, set wins over clear
   always_comb begin
      irq_mask_d = irq_mask_q;
      if (wr && idx == radio_rx_pkg::IDX_IRQ_MASK_LO) begin
         irq_mask_d[7:0] = wbyte;
      end
      if (wr && idx == radio_rx_pkg::IDX_IRQ_MASK_HI) begin
         irq_mask_d[14:8] = wbyte[6:0];
      end
      irq_mask_d = irq_mask_d & radio_rx_pkg::IRQ_IMPL;
      events     = {1'b0, irq_src_in.hi, 1'b0, irq_src_in.lo};
      events[radio_rx_pkg::BIT_MASK_EMPTY] = (rx_mask_q != 8'h00) && (rx_mask_d == 8'h00);
      clr_bits = 15'h0000;
      if (wr && idx == radio_rx_pkg::IDX_IRQ_STAT_LO) begin
         clr_bits[7:0] = wbyte;
      end
      if (wr && idx == radio_rx_pkg::IDX_IRQ_STAT_HI) begin
         clr_bits[14:8] = wbyte[6:0];
      end
      irq_stat_d = ((irq_stat_q & ~clr_bits) | events) & radio_rx_pkg::IRQ_IMPL;
      irq_d      = |(irq_stat_q & irq_mask_q);
   end

   // controls towards the radio
   always_comb begin
      pend_d  = opts_q[radio_rx_pkg::BIT_PEND_OVR] | fsm_pending_in;
      // when skipped, the transmitter runs on to the frame length with no abort
      abort_d = tx_underflow_in && !opts_q[radio_rx_pkg::BIT_SKIP_UNDER];
      rx_on_d = (rx_mask_q != 8'h00) && (fsm_in.idle || fsm_in.tx_done || fsm_in.ack_done);
      mode_out_d = {rx_mode_q == radio_rx_pkg::RX_MODE_NORMAL,
                    rx_mode_q == radio_rx_pkg::RX_MODE_LOOP,
                    rx_mode_q == radio_rx_pkg::RX_MODE_NOSYNC};
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         opts_q     <= radio_rx_pkg::FRAME_OPTS_RST;
         rx_mask_q  <= radio_rx_pkg::RX_MASK_RST;
         irq_mask_q <= radio_rx_pkg::IRQ_RST;
         irq_stat_q <= radio_rx_pkg::IRQ_RST;
         rx_mode_q  <= radio_rx_pkg::RX_MODE_NORMAL;
         ack_q      <= 1'b0;
         rdat_q     <= 32'h0000_0000;
         pend_q     <= 1'b0;
         abort_q    <= 1'b0;
         rx_on_q    <= 1'b0;
         mode_out_q <= 3'h4;
         irq_q      <= 1'b0;
      end else begin
         opts_q     <= opts_d;
         rx_mask_q  <= rx_mask_d;
         irq_mask_q <= irq_mask_d;
         irq_stat_q <= irq_stat_d;
         rx_mode_q  <= rx_mode_d;
         ack_q      <= ack_d;
         rdat_q     <= rdat_d;
         pend_q     <= pend_d;
         abort_q    <= abort_d;
         rx_on_q    <= rx_on_d;
         mode_out_q <= mode_out_d;
         irq_q      <= irq_d;
      end
   end

   assign wb_ack_out              = ack_q;
   assign wb_dat_out              = rdat_q;
   assign ack_pending_out         = pend_q;
   assign tx_abort_out            = abort_q;
   assign receiver_on_out         = rx_on_q;
   assign rx_to_fifo_out          = mode_out_q[2];
   assign rx_ignore_overflow_out  = mode_out_q[1];
   assign symbol_search_off_out   = mode_out_q[0];
   assign receive_enable_mask_out = rx_mask_q;
   assign irq_out                 = irq_q;

endmodule : radio_rx_enable_and_irq_masks

// >>> sim/radio_rx_monitor.sv
// checker for the receive-enable mask and radio control outputs
`timescale 1ns/1ps
module radio_rx_monitor (
   // clock and reset
   input wire logic                     clk_in,
   input wire logic                     rst_in,
   // bus
   input wire logic                     wb_cyc_in,
   input wire logic                     wb_stb_in,
   input wire logic                     wb_we_in,
   input wire logic [17:0]              wb_adr_in,
   input wire logic [3:0]               wb_sel_in,
   input wire logic [31:0]              wb_dat_in,
   input wire logic                     wb_ack_out,
   // radio side
   input wire radio_rx_pkg::strobes_s   strobes_in,
   input wire radio_rx_pkg::fsm_state_s fsm_in,
   input wire logic                     fsm_pending_in,
   input wire logic                     tx_underflow_in,
   input wire logic                     ack_pending_out,
   input wire logic                     tx_abort_out,
   input wire logic                     receiver_on_out,
   input wire logic [7:0]               receive_enable_mask_out
);
   logic       wr;
   logic       set_wr;
   logic       clr_wr;
   logic [7:0] m;
   assign wr = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out & wb_sel_in[0];
   assign set_wr = wr & (wb_adr_in[17:2] == radio_rx_pkg::IDX_MASK_SET);
   assign clr_wr = wr & (wb_adr_in[17:2] == radio_rx_pkg::IDX_MASK_CLR);
   assign m = receive_enable_mask_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_rx_on_bit: assert property (strobes_in.rx_on && !strobes_in.rf_off && !wr |=> m[7])
      else $error("bit 7 not set");
   a_off_clear: assert property (strobes_in.rf_off && !wr |=> m == 8'h00)
      else $error("mask not cleared");
   a_set_or: assert property (set_wr |=> (m & $past(wb_dat_in[7:0])) == $past(wb_dat_in[7:0]))
      else $error("set port lost");
   a_clr_and: assert property (clr_wr |=> (m & $past(wb_dat_in[7:0])) == 8'h00)
      else $error("clear port lost");
   a_mask_hold: assert property (!wr && strobes_in == '0 |=> $stable(m))
      else $error("mask moved");
   a_pend_follow: assert property (fsm_pending_in |=> ack_pending_out)
      else $error("pending lost");
   a_abort_cause: assert property (tx_abort_out |-> $past(tx_underflow_in))
      else $error("abort without cause");
   a_rx_turn_on: assert property ((|m) && (|fsm_in) |=> receiver_on_out)
      else $error("receiver not on");
   c_race: cover property (strobes_in.rx_on && clr_wr);
   c_rx_on: cover property (receiver_on_out);
   c_abort: cover property (tx_abort_out);
endmodule : radio_rx_monitor
bind radio_rx_enable_and_irq_masks radio_rx_monitor i_mon (.*);

// >>> sim/strobe_proc_model.sv
// strobe processor model issuing single-cycle strobes
`timescale 1ns/1ps
module strobe_proc_model (
   // clock
   input wire logic               clk_in,
   // strobes towards the mask
   output radio_rx_pkg::strobes_s strobes_out
);
   initial strobes_out = '0;
   // races a bus write only when a scenario forks the two on purpose
   task automatic fire(input logic [4:0] s);
      @(posedge clk_in);
      strobes_out <= s;
      @(posedge clk_in);
      strobes_out <= '0;
   endtask : fire
endmodule : strobe_proc_model

// >>> sim/radio_rx_enable_and_irq_masks_tb_top.sv
// self-checking bench for the receive-enable mask register bank
`timescale 1ns/1ps
module radio_rx_enable_and_irq_masks_tb_top;
   logic clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, fsm_pending_in, tx_underflow_in;
   logic ack_pending_out, tx_abort_out, receiver_on_out, rx_to_fifo_out, rx_ignore_overflow_out;
   logic symbol_search_off_out, irq_out;
   logic [17:0]              wb_adr_in;
   logic [3:0]               wb_sel_in, sel_q;
   logic [31:0]              wb_dat_in, wb_dat_out, lfsr_q, exp_q[$];
   logic [7:0]               receive_enable_mask_out, r, c;
   radio_rx_pkg::strobes_s   strobes_in;
   radio_rx_pkg::fsm_state_s fsm_in;
   radio_rx_pkg::irq_src_s   irq_src_in;
   int                       error_cnt, checks_done;
   radio_rx_enable_and_irq_masks i_dut (.*);
   strobe_proc_model i_csp (.clk_in, .strobes_out(strobes_in));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      checks_done++;
      if (seen !== want) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   // one classic cycle; a read notes its expected byte
   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [7:0] e);
      int n;
      n = 0;
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_sel_in <= sel_q;
      wb_adr_in <= {idx, 2'b00};
      wb_dat_in <= {24'h0, d};
      if (!w) exp_q.push_back({24'h0, e});
      // ack is sampled at the rising edge; the request is released right after it
      do begin
         @(posedge clk_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 40);
      if (n >= 40) begin
         error_cnt++;
         stop_test();
      end
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask : wb
   task automatic pulse_src(input logic [12:0] v, input logic want);
      @(posedge clk_in);
      irq_src_in <= v;
      @(posedge clk_in);
      irq_src_in <= '0;
      @(posedge clk_in);
      @(negedge clk_in);
      check(irq_out, want, "irq");
   endtask : pulse_src
   always @(negedge clk_in) begin
      if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
         if (exp_q.size() > 0) check(wb_dat_out, exp_q.pop_front(), "read data");
         else error_cnt++;
      end
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      error_cnt++;
      stop_test();
   end
   initial begin
      {wb_cyc_in, wb_stb_in, wb_we_in, fsm_pending_in, tx_underflow_in} = '0;
      wb_adr_in = '0;
      wb_sel_in = 4'h0;
      sel_q = 4'hF;
      wb_dat_in = '0;
      fsm_in = '0;
      irq_src_in = '0;
      lfsr_q = 32'hB2FC5A09;
      error_cnt = 0;
      checks_done = 0;
      rst_in = 1'b1;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      wb(0, radio_rx_pkg::IDX_FRAME_OPTS, 0, 8'h01);
      wb(0, radio_rx_pkg::IDX_MASK_SET, 0, 0);
      wb(0, 16'h6100, 0, 0);
      i_csp.fire(5'h10);
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, 8'h80);
      i_csp.fire(5'h08);
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, 8'hC0);
      i_csp.fire(5'h02);
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, 8'hE0);
      i_csp.fire(5'h01);
      wb(1, radio_rx_pkg::IDX_FRAME_OPTS, 0, 0);
      wb(1, radio_rx_pkg::IDX_MASK_CLR, 8'h40, 0);
      i_csp.fire(5'h08);
      wb(1, radio_rx_pkg::IDX_RX_MASK, 8'hFF, 0);
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, 8'h80);
      for (int j = 0; j < 3; j++) begin
         @(posedge clk_in);
         fsm_in <= 3'(3'b100 >> j);
         @(posedge clk_in);
         fsm_in <= '0;
         @(negedge clk_in);
         check(receiver_on_out, 1, "receiver on");
      end
      i_csp.fire(5'h04);
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, 0);
      wb(0, radio_rx_pkg::IDX_IRQ_STAT_LO, 0, 8'h80);
      $display("strobe test done");
      lfsr_q = lfsr(lfsr_q);
      r = lfsr_q[7:0];
      c = lfsr_q[15:8];
      wb(1, radio_rx_pkg::IDX_MASK_SET, r, 0);
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, r);
      wb(1, radio_rx_pkg::IDX_MASK_CLR, c, 0);
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, r & ~c);
      wb(1, radio_rx_pkg::IDX_MASK_CLR, 8'hFF, 0);
      fork
         i_csp.fire(5'h10);
         wb(1, radio_rx_pkg::IDX_MASK_CLR, 8'h80, 0);
      join
      fork
         i_csp.fire(5'h02);
         wb(1, radio_rx_pkg::IDX_MASK_SET, 8'h01, 0);
      join
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, 8'h21);
      check(receive_enable_mask_out, 8'h21, "mask output");
      // a write without byte lane 0 is acked but must leave the mask alone
      sel_q = 4'hE;
      wb(1, radio_rx_pkg::IDX_MASK_SET, 8'h02, 0);
      sel_q = 4'hF;
      wb(0, radio_rx_pkg::IDX_RX_MASK, 0, 8'h21);
      $display("port test done");
      wb(1, radio_rx_pkg::IDX_IRQ_STAT_LO, 8'hFF, 0);
      wb(1, radio_rx_pkg::IDX_IRQ_MASK_LO, 8'h01, 0);
      pulse_src(13'h0080, 0);
      pulse_src(13'h0040, 1);
      wb(0, radio_rx_pkg::IDX_IRQ_STAT_LO, 0, 8'h03);
      wb(1, radio_rx_pkg::IDX_IRQ_STAT_LO, 8'h01, 0);
      @(negedge clk_in);
      check(irq_out, 0, "irq cleared");
      wb(1, radio_rx_pkg::IDX_IRQ_MASK_HI, 8'hFF, 0);
      wb(0, radio_rx_pkg::IDX_IRQ_MASK_HI, 0, 8'h3F);
      pulse_src(13'h0020, 1);
      $display("interrupt test done");
      for (int i = 0; i < 2; i++) begin
         wb(1, radio_rx_pkg::IDX_FRAME_OPTS, 8'(i << 1), 0);
         @(posedge clk_in);
         tx_underflow_in <= 1'b1;
         @(posedge clk_in);
         tx_underflow_in <= 1'b0;
         @(negedge clk_in);
         check(tx_abort_out, i == 0, "abort");
      end
      lfsr_q = lfsr(lfsr_q);
      @(posedge clk_in);
      fsm_pending_in <= lfsr_q[0];
      @(posedge clk_in);
      fsm_pending_in <= 1'b0;
      @(negedge clk_in);
      check(ack_pending_out, lfsr_q[0], "pending follow");
      wb(1, radio_rx_pkg::IDX_FRAME_OPTS, 8'hFC, 0);
      wb(0, radio_rx_pkg::IDX_FRAME_OPTS, 0, 8'h04);
      @(negedge clk_in);
      check(ack_pending_out, 1, "pending");
      for (int i = 0; i < 4; i++) begin
         wb(1, radio_rx_pkg::IDX_RX_CTRL, 8'(i), 0);
         @(negedge clk_in);
         check({rx_to_fifo_out, rx_ignore_overflow_out, symbol_search_off_out}, 3'(12'h284 >> (3 * i)), "mode");
      end
      $display("option test done");
      stop_test();
   end
endmodule : radio_rx_enable_and_irq_masks_tb_top
